//--- pcrcg_pkg.sv
// Package: constants and carrier types of the programmable CRC generator
package pcrcg_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_TAPS = 4'h1;
	localparam logic [3:0] OFS_DATA = 4'h2;
	localparam logic [3:0] OFS_WDATA = 4'h3;
	localparam int unsigned CTL_LEN_LSB = 0;
	localparam int unsigned CTL_GO_BIT = 4;
	localparam int unsigned CTL_EMPTY_BIT = 6;
	localparam int unsigned CTL_FULL_BIT = 7;
	localparam int unsigned CTL_CNT_LSB = 8;
	localparam int unsigned CTL_IDLE_BIT = 13;
	localparam logic [3:0] LEN_DEEP_MAX = 4'h7;
	localparam logic [4:0] DEPTH_SHALLOW = 5'h08;
	localparam logic [4:0] DEPTH_DEEP = 5'h10;
	localparam int unsigned FIFO_SLOTS = 16;
	localparam logic [15:0] TAPS_MASK = 16'hFFFE;
	localparam logic [3:0] LEN_RESET = 4'h0;
	localparam logic [15:0] TAPS_RESET = 16'h0000;
	localparam logic [15:0] SHIFT_RESET = 16'h0000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pcrcg_bus_req_t;

	typedef struct packed {
		logic go;
		logic idle_stop;
		logic [3:0] len;
		logic [15:0] taps;
	} pcrcg_cfg_t;

	typedef enum logic [0:0] {
		PCRCG_IDLE,
		PCRCG_SHIFT
	} pcrcg_state_t;
endpackage

//--- pcrcg_lfsr.sv
// Galois feedback shift register step of programmable length
`timescale 1ns/1ps
module pcrcg_lfsr (
	input wire logic [15:0] crc_i,
	input wire logic [15:0] taps_i,
	input wire logic [3:0] len_i,
	input wire logic bit_i,
	output logic [15:0] crc_o
);
	import pcrcg_pkg::*;
	logic fb;
	logic [15:0] len_mask;
	always_comb begin
		len_mask = 16'hFFFF >> (4'hF - len_i);
		fb = bit_i ^ crc_i[len_i];
		// Shift up, inject feedback at enabled taps (see RULE19)
		crc_o = ({crc_i[14:0], fb} ^ ({16{fb}} & taps_i & TAPS_MASK)) & len_mask;
	end
endmodule

//--- pcrcg_regs.sv
// Register read multiplexer of the CRC generator
`timescale 1ns/1ps
module pcrcg_regs (
	input wire logic [3:0] addr_i,
	input wire logic [15:0] control_i,
	input wire logic [15:0] taps_i,
	input wire logic [15:0] crc_i,
	output logic [15:0] rdata_o
);
	import pcrcg_pkg::*;
	always_comb begin
		case (addr_i)
			OFS_CONTROL: rdata_o = control_i;
			OFS_TAPS: rdata_o = taps_i & TAPS_MASK; // see RULE2
			OFS_DATA, OFS_WDATA: rdata_o = crc_i; // see RULE20
			default: rdata_o = 16'h0000;
		endcase
	end
endmodule

//--- pcrcg_top.sv
// Programmable CRC generator: registers, word FIFO and serial shifter
// Operation
// RULE1 - Length field holds polynomial length minus one
// RULE2 - Taps 15..1 select XOR terms, bit0 zero
// RULE3 - Software writes go to start, zero stops
// RULE4 - FIFO 8 deep if length above 7
// RULE5 - Byte writes accepted, words length plus one
// RULE6 - Count increments when top byte written
// RULE7 - Shift while go and count nonzero
// RULE8 - One bit shifted per clock cycle
// RULE9 - Full at depth, empty at zero count
// RULE10 - Write while full wraps count to zero
// RULE11 - Interrupt when count falls one to zero
// RULE12 - Software reads result only after empty
// RULE13 - Software flushes by running until empty
// RULE14 - Software waits a cycle before count read
// RULE15 - Software primes FIFO, polls count
// RULE16 - Sleep freezes all state; register reads still load rdata in sleep
// RULE17 - Idle-stop freezes in idle, interrupt passes
// RULE18 - Status read-only, empty resets to one
// RULE19 - Galois feedback at enabled taps
// RULE20 - Result readable through data registers
`timescale 1ns/1ps
module pcrcg_top (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire pcrcg_pkg::pcrcg_bus_req_t bus_i,
	input wire logic [1:0] wbe_i,
	input wire logic sleep_i,
	input wire logic idle_i,
	output logic [15:0] rdata_o,
	output logic irq_o
);
	import pcrcg_pkg::*;

	typedef struct packed {
		pcrcg_cfg_t cfg;
		logic [4:0] count;
		logic [3:0] rd_ptr;
		logic [3:0] wr_ptr;
		logic [3:0] bit_idx;
		logic [15:0] crc;
		logic [15:0] rdata;
		logic irq;
		pcrcg_state_t state;
	} pcrcg_st_t;

	pcrcg_st_t st_r;
	pcrcg_st_t st_nxt;
	logic [15:0] mem_r [FIFO_SLOTS];
	logic [15:0] word_acc_r;
	logic [15:0] mem_wdata;
	logic mem_we;
	logic [4:0] depth;
	logic full;
	logic empty;
	logic frozen;
	logic shift_en;
	logic [15:0] cur_word;
	logic cur_bit;
	logic [15:0] crc_step;
	logic [15:0] control;
	logic [15:0] reg_rdata;
	logic top_lane_hi;
	logic wr_data;
	logic [15:0] merged;

	////////////////////////////////////////////////////////////////////////
	// Status and configuration views
	always_comb begin
		depth = (st_r.cfg.len > LEN_DEEP_MAX) ? DEPTH_SHALLOW : DEPTH_DEEP; // see RULE4
		full = (st_r.count == depth); // see RULE9
		empty = (st_r.count == 5'h00); // see RULE9
		frozen = sleep_i | (idle_i & st_r.cfg.idle_stop); // see RULE16 / RULE17
		shift_en = st_r.cfg.go & !empty & !frozen; // see RULE7
		cur_word = mem_r[st_r.rd_ptr];
		cur_bit = cur_word[st_r.cfg.len - st_r.bit_idx]; // MSb first
		top_lane_hi = (st_r.cfg.len > LEN_DEEP_MAX);
		wr_data = bus_i.wr & (bus_i.addr == OFS_WDATA) & !frozen;
		control = 16'h0000;
		control[CTL_LEN_LSB +: 4] = st_r.cfg.len;
		control[CTL_GO_BIT] = st_r.cfg.go;
		control[CTL_EMPTY_BIT] = empty; // see RULE18
		control[CTL_FULL_BIT] = full;
		control[CTL_CNT_LSB +: 5] = st_r.count;
		control[CTL_IDLE_BIT] = st_r.cfg.idle_stop;
	end

	pcrcg_lfsr u_lfsr (
		.crc_i(st_r.crc),
		.taps_i(st_r.cfg.taps),
		.len_i(st_r.cfg.len),
		.bit_i(cur_bit),
		.crc_o(crc_step)
	);

	pcrcg_regs u_regs (
		.addr_i(bus_i.addr),
		.control_i(control),
		.taps_i(st_r.cfg.taps),
		.crc_i(st_r.crc),
		.rdata_o(reg_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of the write-data register
	always_comb begin
		merged = word_acc_r;
		if (wbe_i[0]) begin
			merged[7:0] = bus_i.wdata[7:0]; // see RULE5
		end
		if (wbe_i[1]) begin
			merged[15:8] = bus_i.wdata[15:8];
		end
		mem_wdata = merged;
		// Word completes when the lane holding its MSb is written
		mem_we = wr_data & (top_lane_hi ? wbe_i[1] : wbe_i[0]); // see RULE6
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		st_nxt.rdata = bus_i.rd ? reg_rdata : 16'h0000;
		if (bus_i.wr && !frozen) begin
			case (bus_i.addr)
				OFS_CONTROL: begin
					st_nxt.cfg.len = bus_i.wdata[CTL_LEN_LSB +: 4]; // see RULE1
					st_nxt.cfg.go = bus_i.wdata[CTL_GO_BIT]; // see RULE3
					st_nxt.cfg.idle_stop = bus_i.wdata[CTL_IDLE_BIT];
				end
				OFS_TAPS: st_nxt.cfg.taps = bus_i.wdata & TAPS_MASK; // see RULE2
				OFS_DATA: st_nxt.crc = bus_i.wdata;
				default: st_nxt.cfg = st_r.cfg;
			endcase
		end
		if (!frozen) begin
			case (st_r.state)
				PCRCG_IDLE: begin
					st_nxt.bit_idx = 4'h0;
					if (shift_en) begin
						st_nxt.state = PCRCG_SHIFT;
					end
				end
				PCRCG_SHIFT: begin
					if (!st_r.cfg.go || empty) begin
						st_nxt.state = PCRCG_IDLE;
					end
				end
				default: st_nxt.state = PCRCG_IDLE;
			endcase
		end
		if (shift_en) begin
			st_nxt.crc = crc_step; // see RULE8
			if (st_r.bit_idx == st_r.cfg.len) begin
				st_nxt.bit_idx = 4'h0;
				st_nxt.rd_ptr = st_r.rd_ptr + 4'h1;
				st_nxt.count = st_r.count - 5'h01; // see RULE7
				if (st_r.count == 5'h01 && !mem_we) begin
					st_nxt.irq = 1'b1; // see RULE11
				end
			end else begin
				st_nxt.bit_idx = st_r.bit_idx + 4'h1;
			end
		end
		if (mem_we) begin
			st_nxt.wr_ptr = st_r.wr_ptr + 4'h1;
			if (full) begin
				st_nxt.count = 5'h00; // see RULE10
				st_nxt.rd_ptr = st_r.wr_ptr + 4'h1;
				st_nxt.bit_idx = 4'h0;
			end else begin
				st_nxt.count = st_nxt.count + 5'h01; // see RULE6
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= '{cfg: '{go: 1'b0, idle_stop: 1'b0, len: LEN_RESET,
				taps: TAPS_RESET}, count: 5'h00, rd_ptr: 4'h0, wr_ptr: 4'h0,
				bit_idx: 4'h0, crc: SHIFT_RESET, rdata: 16'h0000, irq: 1'b0,
				state: PCRCG_IDLE}; // see RULE18
			word_acc_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			if (wr_data) begin
				word_acc_r <= merged;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (mem_we) begin
			mem_r[st_r.wr_ptr] <= mem_wdata;
		end
	end

	assign rdata_o = st_r.rdata;
	assign irq_o = st_r.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_depth;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		st_r.count <= depth;
	endproperty
	a_depth: assert property (p_depth) else $error("count above depth"); // see RULE4

	property p_irq;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		irq_o |-> $past(st_r.count) == 5'h01 && empty;
	endproperty
	a_irq: assert property (p_irq) else $error("irq without 1 to 0"); // see RULE11

	property p_wrap;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		mem_we && full |=> empty && !irq_o;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap on full"); // see RULE10

	property p_noshift;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!st_r.cfg.go && !(bus_i.wr && bus_i.addr == OFS_DATA) |=> $stable(st_r.crc);
	endproperty
	a_noshift: assert property (p_noshift) else $error("shift without go"); // see RULE7

	property p_freeze;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		sleep_i |=> $stable(st_r.count) && $stable(st_r.crc);
	endproperty
	a_freeze: assert property (p_freeze) else $error("moved in sleep"); // see RULE16

	property p_idle;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		idle_i && st_r.cfg.idle_stop |=> $stable(st_r.count);
	endproperty
	a_idle: assert property (p_idle) else $error("moved in idle"); // see RULE17

	property p_inc;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		mem_we && !full && !shift_en |=> st_r.count == $past(st_r.count) + 5'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("count not bumped"); // see RULE6

	property p_taps0;
		@(posedge ref_clk_i) disable iff (!resetn_i)
		bus_i.rd && bus_i.addr == OFS_TAPS |=> !rdata_o[0];
	endproperty
	a_taps0: assert property (p_taps0) else $error("tap 0 set"); // see RULE2
endmodule

//--- test_programmable_crc_generator.sv
// Self-checking testbench of the programmable CRC generator
`timescale 1ns/1ps
module test_programmable_crc_generator;
	import pcrcg_pkg::*;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic sleep_i = 1'b0;
	logic idle_i = 1'b0;
	logic irq_o;
	pcrcg_bus_req_t bus_i = '0;
	logic [1:0] wbe_i = 2'h0;
	logic [15:0] rdata_o;
	logic [15:0] v;
	int n_fail = 0;
	int checked = 0;
	int n_irq = 0;

	////////////////////////////////////////////////////////////////////////
	always #25 ref_clk_i = ~ref_clk_i;

	pcrcg_top uut (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.bus_i(bus_i),
		.wbe_i(wbe_i),
		.sleep_i(sleep_i),
		.idle_i(idle_i),
		.rdata_o(rdata_o),
		.irq_o(irq_o)
	);

	always @(posedge ref_clk_i) begin
		if (irq_o === 1'b1) begin
			n_irq <= n_irq + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task results;
		$display("fails %0d checks %0d", n_fail, checked);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task bwr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge ref_clk_i);
		bus_i.addr <= a;
		bus_i.wdata <= d;
		bus_i.wr <= 1'b1;
		wbe_i <= be;
		@(posedge ref_clk_i);
		bus_i.wr <= 1'b0;
	endtask

	task brd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		bus_i.addr <= a;
		bus_i.rd <= 1'b1;
		@(posedge ref_clk_i);
		bus_i.rd <= 1'b0;
		#1 d = rdata_o;
	endtask

	// One Galois step, message bit in at the top
	function automatic logic [15:0] step(logic [15:0] c, logic [15:0] t,
		logic [3:0] l, logic b);
		logic [15:0] m;
		logic fb;
		m = 16'hFFFF >> (4'hF - l);
		fb = b ^ c[l];
		c = (c << 1) & m;
		if (fb) begin
			c = c ^ ({t[15:1], 1'b1} & m);
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Fill to depth, then one write too many
	task fill(input logic [3:0] l);
		logic [15:0] r;
		int d;
		int k0;
		d = (l > LEN_DEEP_MAX) ? 8 : 16;
		k0 = n_irq;
		bwr(OFS_CONTROL, {12'h000, l}, 2'h3);
		for (int i = 0; i < d; i++) begin
			bwr(OFS_WDATA, 16'($urandom), 2'h3);
		end
		brd(OFS_CONTROL, r);
		chk(r, {3'h0, 5'(d), 4'h8, l});
		bwr(OFS_WDATA, 16'($urandom), 2'h3);
		brd(OFS_CONTROL, r);
		chk(r, {8'h00, 4'h4, l});
		chk(16'(n_irq), 16'(k0));
	endtask

	// Queue words, shift them, compare result and, when not frozen, timing
	task run(input logic [3:0] l, input int n, input logic frz);
		logic [15:0] crc;
		logic [15:0] t;
		logic [15:0] w;
		logic [15:0] r;
		logic [15:0] m;
		int cyc;
		m = 16'hFFFF >> (4'hF - l);
		t = 16'($urandom);
		crc = 16'($urandom) & m;
		bwr(OFS_CONTROL, {12'h000, l}, 2'h3);
		bwr(OFS_TAPS, t, 2'h3);
		bwr(OFS_DATA, crc, 2'h3);
		for (int i = 0; i < n; i++) begin
			w = 16'($urandom) & m;
			if (l > LEN_DEEP_MAX && i[0]) begin
				bwr(OFS_WDATA, {8'h00, w[7:0]}, 2'h1);
				bwr(OFS_WDATA, {w[15:8], 8'h00}, 2'h2);
			end else begin
				bwr(OFS_WDATA, w, (l > LEN_DEEP_MAX) ? 2'h3 : 2'h1);
			end
			for (int b = int'(l); b >= 0; b--) begin
				crc = step(crc, t, l, w[b]);
			end
		end
		brd(OFS_CONTROL, r);
		chk(r, {3'h0, 5'(n), 4'h0, l});
		bwr(OFS_CONTROL, {2'h0, frz, 8'h00, 1'b1, l}, 2'h3);
		if (frz) begin
			repeat (5) @(posedge ref_clk_i);
		end
		idle_i <= 1'b1;
		if (frz) begin
			repeat (40) @(posedge ref_clk_i);
			brd(OFS_CONTROL, r);
			chk(r, {2'h0, 1'b1, 5'(n), 4'h1, l});
			@(posedge ref_clk_i);
			idle_i <= 1'b0;
			sleep_i <= 1'b1;
			repeat (40) @(posedge ref_clk_i);
			brd(OFS_CONTROL, r);
			chk(r, {2'h0, 1'b1, 5'(n), 4'h1, l});
			@(posedge ref_clk_i);
			sleep_i <= 1'b0;
		end
		#1 cyc = 0;
		while (irq_o !== 1'b1 && cyc < 400) begin
			@(posedge ref_clk_i);
			#1 cyc++;
		end
		chk(16'(irq_o), 16'h0001);
		if (!frz) begin
			chk(16'(cyc), 16'((int'(l) + 1) * n));
		end
		@(posedge ref_clk_i);
		idle_i <= 1'b0;
		#1 chk(16'(irq_o), 16'h0000);
		brd(OFS_WDATA, r);
		chk(r, crc);
		brd(OFS_CONTROL, r);
		chk(r, {2'h0, frz, 5'h00, 4'h5, l});
		bwr(OFS_CONTROL, 16'h0000, 2'h3);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		v = 16'($urandom(31));
		repeat (12) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		brd(OFS_CONTROL, v);
		chk(v, 16'h0040);
		brd(OFS_TAPS, v);
		chk(v, TAPS_RESET);
		bwr(OFS_TAPS, 16'hFFFF, 2'h3);
		brd(OFS_TAPS, v);
		chk(v, TAPS_MASK);
		bwr(OFS_CONTROL, 16'hFFFF, 2'h3);
		brd(OFS_CONTROL, v);
		chk(v, 16'h205F);
		brd(4'hC, v);
		chk(v, 16'h0000);
		bwr(OFS_CONTROL, 16'h0000, 2'h3);
		fill(4'h7);
		fill(4'h8);
		run(4'hF, 3, 1'b0);
		run(4'h4, 5, 1'b0);
		run(4'h8, 2, 1'b0);
		run(4'hF, 3, 1'b1);
		repeat (6) run(4'($urandom), $urandom_range(7, 1), 1'b0);
		results;
	end

	initial begin
		#1000000;
		n_fail++;
		results;
	end
endmodule
